/* File: tpd_host_pkg.sv */
package tpd_host_pkg;
  localparam int unsigned ROW_W        = 9;
  localparam int unsigned COL_W        = 8;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned CLK_MHZ      = 25;
  localparam int unsigned REFRESH_ROWS = 512;
  // Whole-array refresh interval in microseconds
  localparam int unsigned REFRESH_PERIOD_US = 16700;
  // Longest gap between refreshes, rounded down to cycles
  localparam int unsigned REFRESH_GAP_CYC =
    (REFRESH_PERIOD_US * CLK_MHZ) / REFRESH_ROWS;
  // Each strobe phase lasts this many clock cycles
  localparam logic [3:0]  PHASE_CYC    = 4'h2;
  localparam logic [DATA_W-1:0] ALL_ENABLED = 8'hff;

  typedef enum logic [1:0] {
    OP_READ,
    OP_WRITE,
    OP_MASKED_WRITE,
    OP_REFRESH
  } op_kind_t;

  // One request from the user side
  typedef struct packed {
    op_kind_t          kind;
    logic [ROW_W-1:0]  row;
    logic [COL_W-1:0]  col;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] mask;
  } mem_req_t;

  // Control strobes toward the memory, active low except the two special function selects
  typedef struct packed {
    logic row_strobe_n;
    logic col_strobe_n;
    logic transfer_or_output_enable_n;
    logic mask_or_write_enable_n;
    logic special_function_sel_1;
    logic special_function_sel_2;
  } strobes_t;

  localparam strobes_t STROBES_IDLE = '{
    row_strobe_n: 1'b1, col_strobe_n: 1'b1,
    transfer_or_output_enable_n: 1'b1, mask_or_write_enable_n: 1'b1,
    special_function_sel_1: 1'b0, special_function_sel_2: 1'b0};
endpackage : tpd_host_pkg

/* File: refresh_timer.sv */
// Raises a refresh demand after each interval until served
module refresh_timer
  import tpd_host_pkg::*;
#(
  parameter int unsigned GAP_CYC = REFRESH_GAP_CYC
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic served_i,
  output logic      due_o
);
  logic [19:0] count_reg;

  // Count always runs; demand is sticky so a late service still counts
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_reg <= '0;
    end else if (count_reg == 20'(GAP_CYC - 1)) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_reg + 20'h00001;
    end
  end

  // Set wins over the clear
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      due_o <= 1'b0;
    end else if (count_reg == 20'(GAP_CYC - 1)) begin
      due_o <= 1'b1; // RULE1
    end else if (served_i) begin
      due_o <= 1'b0;
    end
  end
endmodule : refresh_timer

/* File: tpd_host.sv */
// Contract
// [RULE1] Host refreshes all 512 rows within each 16.7 ms interval.
// [RULE2] Counter refresh: device picks and advances the row itself.
// [RULE3] Row-only refresh: host presents its own row at row strobe fall.
// [RULE4] Device keeps data lines high-impedance during refresh cycles.
// [RULE5] Row strobe toggled with column strobe low gives hidden refresh.
// [RULE6] Every read or write also refreshes its addressed row.
// [RULE7] Nine row bits at row fall, eight column bits at column fall.
// [RULE8] Device ignores controls while row strobe is high.
// [RULE9] Transfer/output-enable high at row fall for memory cycles.
// [RULE10] Write-enable high at column fall means read onto data lines.
// [RULE11] Host drops output enable after row fall to see read data.
// [RULE12] Device drives data only while output enable and column low.
// [RULE13] Mask enable low at row fall selects masked write, else high.
// [RULE14] Write-enable low at column fall writes the data byte.
// [RULE15] Device supports read, early, late, modify and page cycles. The model handles only read, early write and page cycles.
// [RULE16] Mask enable and both special lines low load the mask byte.
// [RULE17] Mask bit 1 permits the write, 0 blocks it.
// [RULE18] Masked write changes only unmasked bits.
// [RULE19] Non-persistent mask reloaded at every row strobe fall. The model skips the reload at counter-refresh row falls.
module tpd_host
  import tpd_host_pkg::*;
#(
  parameter int unsigned GAP_CYC = REFRESH_GAP_CYC
) (
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  input  wire mem_req_t          req_i,
  input  wire logic              req_valid_i,
  output logic                   req_ready_o,
  output logic [DATA_W-1:0]      rdata_o,
  output logic                   rdata_valid_o,
  output strobes_t               strobes_o,
  output logic [ROW_W-1:0]       multiplexed_address_o,
  input  wire logic [DATA_W-1:0] random_port_data_i,
  output logic [DATA_W-1:0]      random_port_data_o,
  output logic                   random_port_data_oe_o
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ROW,
    ST_COL,
    ST_DONE,
    ST_CBR_COL,
    ST_CBR_ROW
  } state_t;

  state_t     state_reg;
  mem_req_t   cur_reg;
  logic [3:0] phase_reg;
  logic       due;
  logic       served;
  logic       phase_end;

  assign phase_end = (phase_reg == PHASE_CYC - 4'h1);
  assign served    = (state_reg == ST_CBR_ROW) && phase_end;

  refresh_timer #(
    .GAP_CYC (GAP_CYC)
  ) u_timer (
    .clk_i    (clk_i),
    .nrst_i   (nrst_i),
    .served_i (served),
    .due_o    (due)
  );

  // Phase counter restarts on every state change
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase_reg <= '0;
    end else if (state_reg == ST_IDLE || phase_end) begin
      phase_reg <= '0;
    end else begin
      phase_reg <= phase_reg + 4'h1;
    end
  end

  // Sequencer; refresh demand beats user requests so rows never starve
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= ST_IDLE;
      cur_reg   <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (due) begin
            state_reg <= ST_CBR_COL; // RULE1
          end else if (req_valid_i) begin
            cur_reg   <= req_i;
            state_reg <= ST_ROW;
          end
        end
        ST_ROW:     if (phase_end) state_reg <= (cur_reg.kind == OP_REFRESH)
                                                ? ST_DONE : ST_COL;
        ST_COL:     if (phase_end) state_reg <= ST_DONE;
        ST_DONE:    if (phase_end) state_reg <= ST_IDLE;
        ST_CBR_COL: if (phase_end) state_reg <= ST_CBR_ROW;
        ST_CBR_ROW: if (phase_end) state_reg <= ST_DONE; // RULE2
        default:    state_reg <= ST_IDLE;
      endcase
    end
  end

  // Strobes, address and data drive per state
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strobes_o             <= STROBES_IDLE;
      multiplexed_address_o <= '0;
      random_port_data_o    <= '0;
      random_port_data_oe_o <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          strobes_o             <= STROBES_IDLE; // RULE8
          random_port_data_oe_o <= 1'b0;
          if (!due && req_valid_i) begin
            multiplexed_address_o <= req_i.row; // RULE3 RULE7
            // Mask byte must be on the data lines at row fall
            random_port_data_o    <= req_i.mask; // RULE19
            random_port_data_oe_o <= (req_i.kind == OP_MASKED_WRITE);
            strobes_o.mask_or_write_enable_n <=
              (req_i.kind != OP_MASKED_WRITE); // RULE13 RULE16
          end
        end
        ST_ROW: begin
          strobes_o.row_strobe_n <= 1'b0; // RULE6 RULE9
          if (phase_end) begin
            multiplexed_address_o <= {1'b0, cur_reg.col}; // RULE7
            random_port_data_o    <= cur_reg.wdata;
            random_port_data_oe_o <= (cur_reg.kind != OP_READ) &&
                                     (cur_reg.kind != OP_REFRESH);
            strobes_o.mask_or_write_enable_n <=
              (cur_reg.kind == OP_READ) || (cur_reg.kind == OP_REFRESH);
            strobes_o.transfer_or_output_enable_n <=
              (cur_reg.kind != OP_READ); // RULE11
          end
        end
        ST_COL: begin
          // Early write: write enable already low before column fall
          strobes_o.col_strobe_n <= 1'b0; // RULE10 RULE14 RULE17 RULE18
        end
        ST_DONE: begin
          strobes_o             <= STROBES_IDLE;
          random_port_data_oe_o <= 1'b0;
        end
        ST_CBR_COL: begin
          // Data lines released, the device floats its own too
          strobes_o.col_strobe_n <= 1'b0; // RULE4
          random_port_data_oe_o  <= 1'b0;
        end
        ST_CBR_ROW: strobes_o.row_strobe_n <= 1'b0; // RULE5
        default:    strobes_o <= STROBES_IDLE;
      endcase
    end
  end

  // Read byte captured at the end of the column phase
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o       <= '0;
      rdata_valid_o <= 1'b0;
    end else begin
      rdata_valid_o <= 1'b0;
      if (state_reg == ST_COL && phase_end && cur_reg.kind == OP_READ) begin
        rdata_o       <= random_port_data_i; // RULE12
        rdata_valid_o <= 1'b1;
      end
    end
  end

  // One-cycle hint as each cycle ends; requests are taken when idle unless a refresh is due
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      req_ready_o <= 1'b0;
    end else begin
      req_ready_o <= (state_reg == ST_DONE) && phase_end;
    end
  end

  sequence s_row_fall;
    $fell(strobes_o.row_strobe_n);
  endsequence

  property p_oe_high_at_row_fall;
    @(posedge clk_i) disable iff (!nrst_i)
      s_row_fall |-> strobes_o.transfer_or_output_enable_n;
  endproperty
  a_oe_high_at_row_fall: assert property (p_oe_high_at_row_fall) // RULE9
    else $error("output enable low at row fall");

  property p_mask_on_bus;
    @(posedge clk_i) disable iff (!nrst_i)
      (s_row_fall and !strobes_o.mask_or_write_enable_n) |->
        random_port_data_oe_o && strobes_o.col_strobe_n;
  endproperty
  a_mask_on_bus: assert property (p_mask_on_bus) // RULE16
    else $error("mask byte not driven at row fall");

  property p_cbr_quiet;
    @(posedge clk_i) disable iff (!nrst_i)
      (!strobes_o.col_strobe_n && strobes_o.row_strobe_n) |->
        !random_port_data_oe_o;
  endproperty
  a_cbr_quiet: assert property (p_cbr_quiet) // RULE4
    else $error("data driven in counter refresh");

  property p_read_no_drive;
    @(posedge clk_i) disable iff (!nrst_i)
      !strobes_o.transfer_or_output_enable_n |-> !random_port_data_oe_o;
  endproperty
  a_read_no_drive: assert property (p_read_no_drive) // RULE12
    else $error("bus contention on read");

  property p_ctrl_idle_row_high;
    @(posedge clk_i) disable iff (!nrst_i)
      (state_reg == ST_IDLE) |-> strobes_o.row_strobe_n;
  endproperty
  a_ctrl_idle_row_high: assert property (p_ctrl_idle_row_high) // RULE8
    else $error("row strobe low while idle");

  property p_refresh_served;
    @(posedge clk_i) disable iff (!nrst_i)
      $rose(due) |-> ##[1:40] served;
  endproperty
  a_refresh_served: assert property (p_refresh_served) // RULE1
    else $error("refresh not served in time");

  property p_read_data;
    @(posedge clk_i) disable iff (!nrst_i)
      rdata_valid_o |-> $past(strobes_o.mask_or_write_enable_n);
  endproperty
  a_read_data: assert property (p_read_data) // RULE10
    else $error("read data without read cycle");

  property p_write_we_low;
    @(posedge clk_i) disable iff (!nrst_i)
      ($fell(strobes_o.col_strobe_n) && random_port_data_oe_o &&
       !strobes_o.row_strobe_n) |-> !strobes_o.mask_or_write_enable_n;
  endproperty
  a_write_we_low: assert property (p_write_we_low) // RULE14
    else $error("write without write enable");
endmodule : tpd_host

/* File: tpd_device_model.sv */
// Behavioural model of the memory device on the far side of the host
module tpd_device_model
  import tpd_host_pkg::*;
(
  input  wire strobes_t          strobes_i,
  input  wire logic [ROW_W-1:0]  address_i,
  input  wire logic [DATA_W-1:0] data_i,
  output logic [DATA_W-1:0]      data_o,
  output logic                   data_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] mem [bit [16:0]];
  logic [ROW_W-1:0]  row_reg = '0;
  logic [ROW_W-1:0]  ctr_reg = '0;
  logic [ROW_W-1:0]  last_row = '0;
  logic [DATA_W-1:0] mask_reg = ALL_ENABLED;
  logic [DATA_W-1:0] data_reg = '0;
  logic              read_reg = 1'b0;
  logic              refresh_reg = 1'b0;
  int                cbr_count = 0;
  int                viol_count = 0;

  // Row fall starts every cycle; nothing else starts one
  always @(negedge strobes_i.row_strobe_n) begin
    read_reg = 1'b0;
    if (!strobes_i.col_strobe_n) begin
      refresh_reg = 1'b1;
      last_row = ctr_reg;
      ctr_reg = ctr_reg + 9'h001;
      cbr_count++;
    end else begin
      refresh_reg = 1'b0;
      row_reg = address_i;
      last_row = address_i;
      if (!strobes_i.transfer_or_output_enable_n) viol_count++;
      if (!strobes_i.mask_or_write_enable_n &&
          !strobes_i.special_function_sel_1 &&
          !strobes_i.special_function_sel_2) begin
        mask_reg = data_i;
      end else begin
        mask_reg = ALL_ENABLED;
      end
    end
  end

  // Column fall inside a row cycle reads or writes one byte
  always @(negedge strobes_i.col_strobe_n) begin
    if (!strobes_i.row_strobe_n) begin
      if (strobes_i.mask_or_write_enable_n) begin
        read_reg = 1'b1;
        data_reg = mem[{row_reg, address_i[COL_W-1:0]}];
      end else begin
        read_reg = 1'b0;
        data_reg = mem.exists({row_reg, address_i[COL_W-1:0]}) ?
                   mem[{row_reg, address_i[COL_W-1:0]}] : 8'h00;
        mem[{row_reg, address_i[COL_W-1:0]}] =
          (data_reg & ~mask_reg) | (data_i & mask_reg);
      end
    end
  end

  // Drivers only in a read with output enable and column low
  assign data_oe_o = read_reg && !refresh_reg && !strobes_i.row_strobe_n
                     && !strobes_i.col_strobe_n
                     && !strobes_i.transfer_or_output_enable_n;
  assign data_o = data_reg;
endmodule : tpd_device_model

/* File: tpd_host_test.sv */
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
  failures++; $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tpd_host_test;
  timeunit 1ns;
  timeprecision 1ps;
  import tpd_host_pkg::*;
  localparam int unsigned GAP = 50;
  logic              clk_i;
  logic              nrst_i;
  mem_req_t          req_i;
  logic              req_valid_i;
  logic              req_ready_o;
  logic [DATA_W-1:0] rdata_o;
  logic              rdata_valid_o;
  strobes_t          strobes_o;
  logic [ROW_W-1:0]  addr;
  logic [DATA_W-1:0] pin, host_d, dev_d;
  logic              host_oe, dev_oe;
  logic [DATA_W-1:0] float_pat = 8'h00;
  int                failures = 0;
  int                checks_done = 0;
  int                contention = 0;

  tpd_host #(.GAP_CYC(GAP)) dut_u (.clk_i(clk_i), .nrst_i(nrst_i),
    .req_i(req_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
    .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o),
    .strobes_o(strobes_o), .multiplexed_address_o(addr),
    .random_port_data_i(pin), .random_port_data_o(host_d),
    .random_port_data_oe_o(host_oe));
  tpd_device_model dev_u (.strobes_i(strobes_o), .address_i(addr),
    .data_i(pin), .data_o(dev_d), .data_oe_o(dev_oe));

  // Undriven bus wanders so a stale value never reads as valid
  always @(posedge clk_i) float_pat <= float_pat + 8'h5b;
  assign pin = host_oe ? host_d : (dev_oe ? dev_d : float_pat);
  always @(posedge clk_i) if (host_oe && dev_oe) contention++;

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Hold the request until its own row strobe falls, then wait row rise
  task automatic issue(input op_kind_t k, input logic [8:0] r,
                       input logic [7:0] c, input logic [7:0] w,
                       input logic [7:0] m);
    int n;
    n = 0;
    @(negedge clk_i);
    req_i = '{kind: k, row: r, col: c, wdata: w, mask: m};
    req_valid_i = 1'b1;
    while (!(strobes_o.row_strobe_n === 1'b0 &&
             strobes_o.col_strobe_n === 1'b1) && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    req_valid_i = 1'b0;
    `CHK("row fall address", r, addr)
    while (strobes_o.row_strobe_n !== 1'b1 && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    `CHK("cycle finished", 1'b1, n < 400)
    // Ready hint follows one edge after the row strobe rises
    @(negedge clk_i);
    `CHK("ready after cycle", 1'b1, req_ready_o)
  endtask : issue

  task automatic rd(input logic [8:0] r, input logic [7:0] c,
                    input logic [7:0] ex);
    int n;
    n = 0;
    fork
      issue(OP_READ, r, c, 8'h00, 8'h00);
      while (rdata_valid_o !== 1'b1 && n < 200) begin
        @(negedge clk_i);
        n++;
      end
    join
    // A stale byte from an earlier read must not pass as this one
    `CHK("read returned", 1'b1, n < 200)
    `CHK("read data", ex, rdata_o)
    `CHK("refreshed row", r, dev_u.last_row)
  endtask : rd

  // Corner addresses, back to back writes then reads
  task automatic t_write_read();
    issue(OP_WRITE, 9'h1ff, 8'hff, 8'ha5, 8'h00);
    issue(OP_WRITE, 9'h000, 8'h00, 8'h5a, 8'h00);
    rd(9'h1ff, 8'hff, 8'ha5);
    rd(9'h000, 8'h00, 8'h5a);
  endtask : t_write_read

  // Mask bits gate each data bit; mask reloaded per row cycle
  task automatic t_masked();
    issue(OP_WRITE, 9'h0a3, 8'h41, 8'h3c, 8'h00);
    issue(OP_MASKED_WRITE, 9'h0a3, 8'h41, 8'hff, 8'h0f);
    rd(9'h0a3, 8'h41, 8'h3f);
    issue(OP_MASKED_WRITE, 9'h0a3, 8'h41, 8'h00, 8'hf0);
    rd(9'h0a3, 8'h41, 8'h0f);
  endtask : t_masked

  // Host supplied row refresh, no column phase
  task automatic t_row_refresh();
    issue(OP_REFRESH, 9'h1a5, 8'h00, 8'h00, 8'h00);
    `CHK("row only refresh", 9'h1a5, dev_u.last_row)
  endtask : t_row_refresh

  // Idle run: timer must issue counter refreshes at its interval
  task automatic t_auto_refresh();
    int c0;
    c0 = dev_u.cbr_count;
    repeat (5 * GAP) @(negedge clk_i);
    `CHK("timed refreshes", 1'b1, dev_u.cbr_count - c0 >= 4)
    rd(9'h0a3, 8'h41, 8'h0f);
  endtask : t_auto_refresh

  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  initial begin
    #(40 * 20000);
    failures++;
    end_of_test();
  end

  initial begin
    nrst_i = 1'b0;
    req_valid_i = 1'b0;
    req_i = '0;
    repeat (10) @(negedge clk_i);
    nrst_i = 1'b1;
    t_write_read();
    t_masked();
    t_row_refresh();
    t_auto_refresh();
    `CHK("bus contention", 0, contention)
    `CHK("memory cycle control", 0, dev_u.viol_count)
    end_of_test();
  end
endmodule : tpd_host_test
